// ### rtl/ofs_pkg.sv
// Constants shared by the output fault supervisor.
package ofs_pkg;
    localparam int          NUM_OUT      = 12;
    localparam int          WORD_BITS    = 16;
    localparam int          CLK_HZ       = 50_000_000;
    localparam int          OSC_HZ       = 32_000;
    localparam int          OSC_DIV      = CLK_HZ / OSC_HZ;
    localparam int          LONG_US      = 12_000;
    localparam int          SHORT_US     = 1_500;
    // Delays in oscillator ticks, rounded down.
    localparam int          LONG_TICKS   = LONG_US * (OSC_HZ / 1000) / 1000;
    localparam int          SHORT_TICKS  = SHORT_US * (OSC_HZ / 1000) / 1000;
    localparam int          TMR_W        = 10;
    localparam int          BIT_RESET    = 0;
    localparam int          BIT_OLD      = 13;
    localparam int          BIT_SDEL     = 14;
    localparam int          BIT_SINH     = 15;
    localparam int          ST_TP        = 0;
    localparam int          ST_SCD       = 13;
    localparam int          ST_INH       = 14;
    localparam int          ST_PSF       = 15;
    localparam logic [15:0] IN_RESET     = 16'he000;
endpackage : ofs_pkg

// ### rtl/ofs_delay_timer.sv
// Tick-driven delay timer used for undervoltage and per-output shorts.
`timescale 1ns/1ps
module ofs_delay_timer #(
    parameter int TMR_W = ofs_pkg::TMR_W
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rstSync_b,
    // Control
    input  wire logic             tick,
    input  wire logic             active,
    input  wire logic [TMR_W-1:0] limit,
    // Result
    output logic                  expired
);
    typedef struct packed {
        logic [TMR_W-1:0] count;
        logic             done;
    } ofs_tmr_t;

    ofs_tmr_t st;
    ofs_tmr_t next_st;

    always_comb begin
        next_st = st;
        if (!active) begin
            next_st = '0;
        end else if (tick && !st.done) begin
            if (st.count + 1'b1 >= limit) begin
                next_st.done = 1'b1;
            end else begin
                next_st.count = st.count + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign expired = st.done;
endmodule : ofs_delay_timer

// ### rtl/ofs_output_fault_supervisor.sv
// Fault supervisor: input word, status word, protection and inhibit.
`timescale 1ns/1ps
module ofs_output_fault_supervisor #(
    parameter int NUM_OUT     = ofs_pkg::NUM_OUT,
    parameter int LONG_TICKS  = ofs_pkg::LONG_TICKS,
    parameter int SHORT_TICKS = ofs_pkg::SHORT_TICKS,
    parameter int OSC_DIV     = ofs_pkg::OSC_DIV
) (
    // Clock and reset
    input  wire logic               mclk,
    input  wire logic               rst_b,
    // Serial link pins
    input  wire logic               chipSel_b,
    input  wire logic               serClk,
    input  wire logic               serDataIn,
    output logic                    serDataOut,
    output logic                    serDataOutEn,
    // Analog condition inputs
    input  wire logic               loadSupplyLow,
    input  wire logic               tempPrewarnSet,
    input  wire logic               tempPrewarnClear,
    input  wire logic               tempShutdown,
    input  wire logic               tempSwitchOnOk,
    input  wire logic [NUM_OUT-1:0] overCurrent,
    input  wire logic [NUM_OUT-1:0] openLoadSense,
    input  wire logic               hwInhibit_b,
    // Driver controls
    output logic [NUM_OUT-1:0]      outEnable,
    output logic [NUM_OUT-1:0]      senseCurrentOn,
    // Observed state
    output logic [15:0]             inputWord,
    output logic [15:0]             statusWord
);
    localparam int TMR_W_L = ofs_pkg::TMR_W;
    localparam logic [TMR_W_L-1:0] LONG_L  = TMR_W_L'(LONG_TICKS);
    localparam logic [TMR_W_L-1:0] SHORT_L = TMR_W_L'(SHORT_TICKS);

    initial begin
        if (NUM_OUT != ofs_pkg::NUM_OUT || LONG_TICKS >= 2**TMR_W_L
            || SHORT_TICKS < 1 || OSC_DIV < 2) begin
            $error("ofs: unsupported parameter values");
        end
    end

    // Synchronised reset.
    logic rstMeta_b;
    logic rstSync_b;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rstMeta_b <= 1'b0;
            rstSync_b <= 1'b0;
        end else begin
            rstMeta_b <= 1'b1;
            rstSync_b <= rstMeta_b;
        end
    end

    typedef struct packed {
        logic [2:0]         csSync;
        logic [2:0]         clkSync;
        logic [1:0]         diSync;
        logic [1:0]         uvSync;
        logic [1:0]         pwSetSync;
        logic [1:0]         pwClrSync;
        logic [1:0]         tsdSync;
        logic [1:0]         tonSync;
        logic [1:0]         inhSync;
        logic [NUM_OUT-1:0] ocMeta;
        logic [NUM_OUT-1:0] ocSync;
        logic [NUM_OUT-1:0] olMeta;
        logic [NUM_OUT-1:0] olSync;
        logic [15:0]        shiftIn;
        logic [15:0]        shiftOut;
        logic [4:0]         bitCount;
        logic               dout;
        logic [15:0]        inWord;
        logic [15:0]        outWord;
        logic               tpFlag;
        logic               psfFlag;
        logic               uvOff;
        logic               thermOff;
        logic [NUM_OUT-1:0] shortOff;
        logic [15:0]        oscCount;
        logic               tick;
    } ofs_state_t;

    ofs_state_t st;
    ofs_state_t next_st;

    logic               uvExpired;
    logic [NUM_OUT-1:0] shExpired;
    logic [TMR_W_L-1:0] delayLimit;

    // Internal oscillator stands in as a divided mclk tick.
    assign delayLimit = st.inWord[ofs_pkg::BIT_SDEL] ? LONG_L : SHORT_L;

    ofs_delay_timer #(.TMR_W(TMR_W_L)) uvTimer (
        .mclk      (mclk),
        .rstSync_b (rstSync_b),
        .tick      (st.tick),
        .active    (st.uvSync[1]),
        .limit     (delayLimit),
        .expired   (uvExpired)
    );

    genvar gi;
    generate
        for (gi = 0; gi < NUM_OUT; gi++) begin : gShort
            ofs_delay_timer #(.TMR_W(TMR_W_L)) shTimer (
                .mclk      (mclk),
                .rstSync_b (rstSync_b),
                .tick      (st.tick),
                .active    (st.ocSync[gi]),
                .limit     (delayLimit),
                .expired   (shExpired[gi])
            );
        end
    endgenerate

    logic               csFall;
    logic               csRise;
    logic               clkRise;
    logic               clkFall;
    logic               inhibit;
    logic               status_reset_request;
    logic [NUM_OUT-1:0] cmd;
    logic [NUM_OUT-1:0] stat;
    logic [15:0]        built;

    always_comb begin
        next_st = st;
        csFall  = st.csSync[2] & ~st.csSync[1];
        csRise  = ~st.csSync[2] & st.csSync[1];
        clkRise = ~st.clkSync[2] & st.clkSync[1];
        clkFall = st.clkSync[2] & ~st.clkSync[1];
        status_reset_request     = 1'b0;

        next_st.csSync    = {st.csSync[1:0], chipSel_b};
        next_st.clkSync   = {st.clkSync[1:0], serClk};
        next_st.diSync    = {st.diSync[0], serDataIn};
        next_st.uvSync    = {st.uvSync[0], loadSupplyLow};
        next_st.pwSetSync = {st.pwSetSync[0], tempPrewarnSet};
        next_st.pwClrSync = {st.pwClrSync[0], tempPrewarnClear};
        next_st.tsdSync   = {st.tsdSync[0], tempShutdown};
        next_st.tonSync   = {st.tonSync[0], tempSwitchOnOk};
        next_st.inhSync   = {st.inhSync[0], hwInhibit_b};
        next_st.ocMeta    = overCurrent;
        next_st.ocSync    = st.ocMeta;
        next_st.olMeta    = openLoadSense;
        next_st.olSync    = st.olMeta;

        if (st.oscCount == 16'(OSC_DIV - 1)) begin
            next_st.oscCount = '0;
            next_st.tick     = 1'b1;
        end else begin
            next_st.oscCount = st.oscCount + 16'h0001;
            next_st.tick     = 1'b0;
        end

        if (st.pwSetSync[1]) begin
            next_st.tpFlag = 1'b1;
        end else if (st.pwClrSync[1]) begin
            next_st.tpFlag = 1'b0;
        end

        // Serial word: sample on rising clock, shift out on falling clock.
        if (csFall) begin
            next_st.shiftOut = st.outWord;
            next_st.dout     = st.outWord[ofs_pkg::ST_TP];
            next_st.bitCount = '0;
        end else if (!st.csSync[1]) begin
            if (clkRise) begin
                next_st.shiftIn  = {st.diSync[1], st.shiftIn[15:1]};
                next_st.bitCount = st.bitCount + 5'h01;
            end
            if (clkFall) begin
                next_st.shiftOut = {1'b0, st.shiftOut[15:1]};
                next_st.dout     = st.shiftOut[1];
            end
        end
        if (csRise && st.bitCount == 5'h10) begin
            next_st.inWord = st.shiftIn;
            status_reset_request = st.shiftIn[ofs_pkg::BIT_RESET];
        end // any other count leaves the input word as it was and requests no status reset.
        next_st.inWord[ofs_pkg::BIT_RESET] = 1'b0;

        if (uvExpired) begin
            next_st.psfFlag = 1'b1;
        end else if (status_reset_request) begin
            next_st.psfFlag = 1'b0;
        end
        next_st.uvOff = uvExpired;

        if (st.tsdSync[1]) begin
            next_st.thermOff = 1'b1;
        end else if (status_reset_request && st.tonSync[1]) begin
            next_st.thermOff = 1'b0;
        end

        for (int i = 0; i < NUM_OUT; i++) begin
            if (st.ocSync[i] && (shExpired[i] || st.tpFlag)) begin
                next_st.shortOff[i] = 1'b1;
            end else if (status_reset_request) begin
                next_st.shortOff[i] = 1'b0;
            end
        end

        inhibit = ~st.inWord[ofs_pkg::BIT_SINH] | ~st.inhSync[1];
        cmd     = st.inWord[NUM_OUT:1];
        for (int i = 0; i < NUM_OUT; i++) begin
            if (!st.inWord[ofs_pkg::BIT_OLD] && !cmd[i]) begin
                stat[i] = st.olSync[i];
            end else begin
                stat[i] = cmd[i] & ~st.shortOff[i];
            end
        end
        built = {st.psfFlag, inhibit, |st.shortOff, stat, st.tpFlag};
        if (st.thermOff) begin
            built = 16'hffff;
        end
        if (st.csSync[1] && !csRise) begin
            next_st.outWord = built;
        end
    end

    always_ff @(posedge mclk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            st        <= '0;
            st.inWord <= ofs_pkg::IN_RESET;
            st.csSync <= 3'h7;
            st.inhSync <= 2'h3;
        end else begin
            st <= next_st;
        end
    end

    // Each cause gates independently, so all must clear first.
    assign outEnable = st.inWord[NUM_OUT:1] & ~st.shortOff
                     & {NUM_OUT{~(st.uvOff | st.thermOff | inhibit)}};
    assign senseCurrentOn = {NUM_OUT{~st.inWord[ofs_pkg::BIT_OLD]}}
                          & ~st.inWord[NUM_OUT:1];
    assign serDataOut   = st.dout;
    assign serDataOutEn = ~st.csSync[1];
    assign inputWord    = st.inWord;
    assign statusWord   = st.outWord;
endmodule : ofs_output_fault_supervisor

// ### dv/ofs_mcu_model.sv
// Serial controller model that writes words and peeks at the prewarning.
`timescale 1ns/1ps
module ofs_mcu_model (
    // Clock
    input  wire logic mclk,
    // Serial link
    output logic      chipSel_b,
    output logic      serClk,
    output logic      serDataIn,
    input  wire logic serDataOut
);
    initial begin
        chipSel_b = 1'b1;
        serClk    = 1'b0;
        serDataIn = 1'b0;
    end
    task automatic edges(input int n);
        repeat (n) @(posedge mclk);
    endtask : edges
    // Four clocks per phase keeps the link at 160 ns, inside its limit.
    task automatic send(input logic [15:0] w);
        edges(1);
        chipSel_b <= 1'b0;
        edges(4);
        for (int i = 0; i < 16; i++) begin
            serDataIn <= w[i];
            serClk    <= 1'b0;
            edges(4);
            serClk    <= 1'b1;
            edges(4);
        end
        serClk <= 1'b0;
        edges(4);
        chipSel_b <= 1'b1;
        // An idle data line must not keep the last bit it carried.
        serDataIn <= ~w[15];
        edges(8);
    endtask : send
    task automatic peek(output logic b);
        edges(1);
        chipSel_b <= 1'b0;
        edges(6);
        #1 b = serDataOut;
        edges(1);
        chipSel_b <= 1'b1;
        edges(8);
    endtask : peek
endmodule : ofs_mcu_model

// ### dv/ofs_fault_assertions.sv
// Concurrent checks on the fault supervisor ports.
`timescale 1ns/1ps
module ofs_fault_checker #(
    parameter int NUM_OUT = 12
) (
    // Clock and reset
    input wire logic               mclk,
    input wire logic               rst_b,
    // Pins and conditions
    input wire logic               chipSel_b,
    input wire logic               serDataOut,
    input wire logic               serDataOutEn,
    input wire logic               hwInhibit_b,
    input wire logic               tempShutdown,
    input wire logic [NUM_OUT-1:0] overCurrent,
    // Results
    input wire logic [NUM_OUT-1:0] outEnable,
    input wire logic [NUM_OUT-1:0] senseCurrentOn,
    input wire logic [15:0]        inputWord,
    input wire logic [15:0]        statusWord
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence csDrop;
        $fell(chipSel_b);
    endsequence
    sequence tpOut;
        serDataOutEn && serDataOut == statusWord[ofs_pkg::ST_TP];
    endsequence
    a_peek_shows_tp:
        assert property (csDrop |-> ##[1:4] tpOut)
        else $error("prewarning missing on data out");
    a_word_hold:
        assert property ($changed(inputWord) |-> chipSel_b)
        else $error("input word changed during a transfer");
    a_pin_inhibit:
        assert property ($fell(hwInhibit_b) |-> ##[1:6] outEnable == '0)
        else $error("outputs left on under pin inhibit");
    a_soft_inhibit:
        assert property ((!inputWord[ofs_pkg::BIT_SINH])[*3]
            |-> outEnable == '0)
        else $error("outputs left on under soft inhibit");
    a_hot_off:
        assert property (tempShutdown[*5] |-> outEnable == '0)
        else $error("outputs on during thermal shutdown");
    a_hot_ones:
        assert property ((tempShutdown && chipSel_b)[*8]
            |-> statusWord == 16'hffff)
        else $error("status word not all ones when hot");
    a_psf_off:
        assert property ($rose(statusWord[ofs_pkg::ST_PSF])
            |-> ##[0:2] outEnable == '0)
        else $error("supply fail left outputs on");
    a_short_off:
        assert property ($rose(statusWord[ofs_pkg::ST_SCD])
            |-> ##[0:2] (outEnable & overCurrent) == '0)
        else $error("shorted output left on");
    a_sense_skip:
        assert property ((senseCurrentOn & inputWord[NUM_OUT:1]) == '0)
        else $error("sensing current on a commanded output");
    a_cmd_only:
        assert property ((outEnable & ~inputWord[NUM_OUT:1]) == '0)
        else $error("output on without command");
endmodule : ofs_fault_checker
bind ofs_output_fault_supervisor ofs_fault_checker #(
    .NUM_OUT(NUM_OUT)
) chk_u (.mclk, .rst_b, .chipSel_b, .serDataOut, .serDataOutEn,
    .hwInhibit_b, .tempShutdown, .overCurrent, .outEnable,
    .senseCurrentOn, .inputWord, .statusWord);

// ### dv/tb_top.sv
// Self-checking bench for the output fault supervisor.
`timescale 1ns/1ps
module tb_top;
    logic        mclk = 1'b0, rst_b = 1'b0, hwInhibit_b = 1'b1;
    logic        loadSupplyLow = 1'b0, tempShutdown = 1'b0;
    logic        tempPrewarnSet = 1'b0, tempPrewarnClear = 1'b0;
    logic        tempSwitchOnOk = 1'b0, b;
    logic        chipSel_b, serClk, serDataIn, serDataOut, serDataOutEn;
    logic [11:0] overCurrent = 12'h000, openLoadSense = 12'h000;
    logic [11:0] outEnable, senseCurrentOn;
    logic [15:0] inputWord, statusWord;
    int          fail_count = 0, checks_done = 0;
    // Long delay of 40 clocks against a short one of 8.
    ofs_output_fault_supervisor #(.LONG_TICKS(20), .SHORT_TICKS(4),
        .OSC_DIV(2)) dut_u (.mclk, .rst_b, .chipSel_b, .serClk,
        .serDataIn, .serDataOut, .serDataOutEn, .loadSupplyLow,
        .tempPrewarnSet, .tempPrewarnClear, .tempShutdown,
        .tempSwitchOnOk, .overCurrent, .openLoadSense, .hwInhibit_b,
        .outEnable, .senseCurrentOn, .inputWord, .statusWord);
    ofs_mcu_model mcu_u (.mclk, .chipSel_b, .serClk, .serDataIn,
        .serDataOut);
    always #10 mclk = ~mclk;
    task automatic chk(input string nm, input logic [15:0] s, e);
        checks_done++;
        if (s !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc
    task automatic wr(input logic [15:0] w);
        mcu_u.send(w);
        cyc(2);
    endtask : wr
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    task automatic t_inhibit;
        chk("inputWord", inputWord, 16'he000);
        chk("outEnable", outEnable, 16'h0000);
        wr(16'ha006);
        chk("inputWord", inputWord, 16'ha006);
        chk("outEnable", outEnable, 16'h0003);
        @(posedge mclk) hwInhibit_b <= 1'b0;
        cyc(6);
        chk("outEnable", outEnable, 16'h0000);
        chk("inhibit", statusWord[14], 1'b1);
        @(posedge mclk) hwInhibit_b <= 1'b1;
        cyc(6);
        chk("outEnable", outEnable, 16'h0003);
        wr(16'h2006);
        chk("outEnable", outEnable, 16'h0000);
        wr(16'ha006);
        chk("outEnable", outEnable, 16'h0003);
    endtask : t_inhibit
    task automatic t_short;
        @(posedge mclk) overCurrent <= 12'h001;
        cyc(30);
        chk("outEnable", outEnable, 16'h0002);
        chk("short", statusWord[13], 1'b1);
        @(posedge mclk) overCurrent <= 12'h000;
        cyc(4);
        chk("outEnable", outEnable, 16'h0002);
        wr(16'ha007);
        chk("outEnable", outEnable, 16'h0003);
        chk("short", statusWord[13], 1'b0);
        wr(16'he006);
        @(posedge mclk) overCurrent <= 12'h001;
        cyc(25);
        chk("outEnable", outEnable, 16'h0003);
        cyc(40);
        chk("outEnable", outEnable, 16'h0002);
    endtask : t_short
    task automatic t_prewarn;
        @(posedge mclk) overCurrent <= 12'h002;
        cyc(4);
        @(posedge mclk) tempPrewarnSet <= 1'b1;
        cyc(2);
        @(posedge mclk) tempPrewarnSet <= 1'b0;
        cyc(6);
        chk("outEnable", outEnable, 16'h0000);
        chk("prewarn", statusWord[0], 1'b1);
        mcu_u.peek(b);
        chk("peek", b, 1'b1);
        chk("inputWord", inputWord, 16'he006);
        @(posedge mclk) overCurrent <= 12'h000;
        @(posedge mclk) tempPrewarnClear <= 1'b1;
        cyc(2);
        @(posedge mclk) tempPrewarnClear <= 1'b0;
        cyc(4);
        chk("prewarn", statusWord[0], 1'b0);
        wr(16'he007);
        chk("outEnable", outEnable, 16'h0003);
    endtask : t_prewarn
    task automatic t_supply;
        wr(16'ha006);
        @(posedge mclk) loadSupplyLow <= 1'b1;
        cyc(30);
        chk("outEnable", outEnable, 16'h0000);
        chk("supplyFail", statusWord[15], 1'b1);
        @(posedge mclk) loadSupplyLow <= 1'b0;
        cyc(6);
        chk("outEnable", outEnable, 16'h0003);
        chk("supplyFail", statusWord[15], 1'b1);
        wr(16'ha007);
        chk("supplyFail", statusWord[15], 1'b0);
        chk("inputWord", inputWord, 16'ha006);
    endtask : t_supply
    task automatic t_thermal;
        @(posedge mclk) tempShutdown <= 1'b1;
        cyc(8);
        chk("outEnable", outEnable, 16'h0000);
        chk("statusWord", statusWord, 16'hffff);
        @(posedge mclk) tempShutdown <= 1'b0;
        cyc(6);
        wr(16'ha007);
        chk("outEnable", outEnable, 16'h0000);
        @(posedge mclk) tempSwitchOnOk <= 1'b1;
        cyc(4);
        chk("outEnable", outEnable, 16'h0000);
        wr(16'ha007);
        chk("outEnable", outEnable, 16'h0003);
    endtask : t_thermal
    task automatic t_openload;
        wr(16'h8006);
        chk("sense", senseCurrentOn, 16'h0ffc);
        @(posedge mclk) openLoadSense <= 12'h004;
        cyc(6);
        chk("openLoad", statusWord[4:3], 2'b01);
    endtask : t_openload
    initial begin
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        cyc(6);
        t_inhibit();
        t_short();
        t_prewarn();
        t_supply();
        t_thermal();
        t_openload();
        conclude();
    end
    initial begin
        #200_000;
        fail_count++;
        conclude();
    end
endmodule : tb_top
